/* logic/mft_io.sv */
// input modes, output actions, interrupt vectoring and dma channels of a 16-bit timer
// assumes: apb master on pclk, counter core and dma controller outside, inputs synchronous
// Contract
// - trigger up/down mode: edge on a selects up, edge on b down, b wins
// - level mode: a high counts up, a low counts down, soft direction ignored
// - autodiscrimination: b rise with a low increments, b fall with a low decrements
// - trigger a with clock b: a triggers reg0 action, b clocks the prescaler
// - clock a with trigger b: b captures into reg1, a clocks the prescaler
// - trigger a with gate b: a triggers reg0, counter runs only while b low
// - each output acted on by compare0, compare1, overflow: nop, set, reset, toggle
// - each output control register holds a preset level loaded into the output
// - chip event from overflow when enabled in a, from compare0 when enabled in b
// - five sources in three groups: low vector 110 compare, 100 capture, 000 overflow
// - low vector bits fixed by group, 000 highest; upper five bits from software
// - each source has its own mask bit; bit 7 masks all timer interrupts
// - compare0 or capture0 request while pending still set sets its overrun flag
// - two dma channels: memory into compare0, capture0 out to memory
// - with dma on, compare0/capture0 interrupt only at the channel end of block
// - capture0 dma requests have fixed priority over compare0 requests
// - separate dma mask bits per channel, end-of-block interrupts use the capture0/compare0 masks
// - upper six pointer bits shared by both channels; address and counter pairs
// - memory transfers: pointer bit 1 clear for capture0, set for compare0
// - register transfers: one pointer group, address pointer register unused
// - a word moves as two bytes; second byte forced to top priority 000
// - end of block set again before cleared clears that channel dma mask
`timescale 1ns/1ps
`default_nettype none
`include "mft_io_defs.svh"

module mft_io
	import mft_io_pkg::*;
(
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// pins
	input  wire logic        event_input_a,
	input  wire logic        event_input_b,
	output logic             wave_output_a,
	output logic             wave_output_b,
	// counter core events
	input  wire logic        compare0_event,
	input  wire logic        compare1_event,
	input  wire logic        over_underflow_event,
	input  wire logic        capture0_event,
	input  wire logic        capture1_event,
	// counter core control
	output logic             count_up,
	output logic             step_up,
	output logic             step_down,
	output logic             ext_clock_pulse,
	output logic             count_gate,
	output logic             reg0_trigger,
	output logic             reg1_capture,
	output logic             chip_event,
	// interrupt controller
	output logic             irq_request,
	output logic [7:0]       irq_vector,
	// dma controller
	output logic             dma_request,
	output logic             dma_capture_channel,
	output logic [2:0]       dma_priority,
	output logic [7:0]       dma_counter_ptr,
	output logic [7:0]       dma_address_ptr,
	output logic             dma_address_used,
	input  wire logic        dma_byte_done,
	input  wire logic        dma_block_end
);

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	logic [7:0] input_mode_q, output_a_control_reg_q, output_b_control_reg_q;
	logic [7:0] irq_vector_reg_q, irq_dma_mask_reg_q, timer_flag_reg_q;
	logic [7:0] dma_counter_pointer_reg_q, dma_address_pointer_reg_q;
	logic [1:0] end_of_block_q;
	logic       wave_a_q, wave_b_q, dir_trig_q, a_prev_q, b_prev_q;
	logic       wr, rd_ok;
	logic [31:0] rdata;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	// waits out a frozen clock so no access is lost while state is held
	assign pready = clk_en;
	assign wr     = psel && penable && pwrite && clk_en;

	always_comb begin
		rdata = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (paddr)
			`OFS_INPUT_MODE:   rdata[7:0] = input_mode_q;
			`OFS_OUT_A_CTRL:   rdata[7:0] = output_a_control_reg_q;
			`OFS_OUT_B_CTRL:   rdata[7:0] = output_b_control_reg_q;
			`OFS_IRQ_VECTOR:   rdata[7:0] = irq_vector_reg_q;
			`OFS_IRQ_DMA_MASK: rdata[7:0] = irq_dma_mask_reg_q;
			`OFS_TIMER_FLAG:   rdata[7:0] = timer_flag_reg_q;
			`OFS_DMA_CNT_PTR:  rdata[7:0] = dma_counter_pointer_reg_q;
			`OFS_DMA_ADR_PTR:  rdata[7:0] = dma_address_pointer_reg_q;
			`OFS_DMA_STATUS:   rdata[7:0] = {dir_trig_q, wave_b_q, wave_a_q, 3'h0, end_of_block_q};
			default:           rd_ok = 1'b0;
		endcase
	end

	assign prdata  = (psel && !pwrite) ? rdata : 32'h0000_0000;
	assign pslverr = psel && penable && !rd_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_mode_q              <= `RST_BYTE;
			irq_vector_reg_q          <= `RST_BYTE;
			dma_counter_pointer_reg_q <= `RST_BYTE;
			dma_address_pointer_reg_q <= `RST_BYTE;
		end else if (wr) begin
			if (hit(paddr, `OFS_INPUT_MODE))
				input_mode_q <= {3'h0, pwdata[4:0]};
			if (hit(paddr, `OFS_IRQ_VECTOR))
				irq_vector_reg_q <= {pwdata[7:3], 3'h0};
			if (hit(paddr, `OFS_DMA_CNT_PTR))
				dma_counter_pointer_reg_q <= pwdata[7:0];
			if (hit(paddr, `OFS_DMA_ADR_PTR))
				dma_address_pointer_reg_q <= pwdata[7:0];
		end
	end

	// ---------------------------------------------------------------
	// input pin modes
	// ---------------------------------------------------------------
	logic [3:0] mode;
	logic       a_rise, b_rise, b_fall, a_edge, b_edge;
	assign mode   = input_mode_q[3:0];
	assign a_rise = event_input_a && !a_prev_q;
	assign b_rise = event_input_b && !b_prev_q;
	assign b_fall = !event_input_b && b_prev_q;
	assign a_edge = a_rise || (!event_input_a && a_prev_q);
	assign b_edge = b_rise || b_fall;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_prev_q   <= 1'b0;
			b_prev_q   <= 1'b0;
			dir_trig_q <= 1'b1;
		end else if (clk_en) begin
			a_prev_q <= event_input_a;
			b_prev_q <= event_input_b;
			if (mode == `MODE_TRIG_UD && b_edge)
				dir_trig_q <= 1'b0;
			else if (mode == `MODE_TRIG_UD && a_edge)
				dir_trig_q <= 1'b1;
		end
	end

	always_comb begin
		unique case (mode)
			`MODE_TRIG_UD:  count_up = dir_trig_q;
			`MODE_LEVEL_UD: count_up = event_input_a;
			default:        count_up = input_mode_q[`INM_SOFT_DIR];
		endcase
	end

	assign step_up   = clk_en && mode == `MODE_AUTODISC && b_rise && !event_input_a;
	assign step_down = clk_en && mode == `MODE_AUTODISC && b_fall && !event_input_a;
	assign ext_clock_pulse = clk_en && ((mode == `MODE_TRIG_EXTB && b_rise) ||
		(mode == `MODE_EXTA_TRIG && a_rise));
	assign reg0_trigger = clk_en && a_rise &&
		(mode == `MODE_TRIG_EXTB || mode == `MODE_TRIG_GATE);
	assign reg1_capture = clk_en && mode == `MODE_EXTA_TRIG && b_rise;
	assign count_gate   = (mode == `MODE_TRIG_GATE) ? !event_input_b : 1'b1;

	// ---------------------------------------------------------------
	// output actions
	// ---------------------------------------------------------------
	function automatic logic act(input logic cur, input logic ev, input logic [1:0] code);
		if (!ev)
			return cur;
		unique case (action_t'(code))
			act_nop:    return cur;
			act_set:    return 1'b1;
			act_reset:  return 1'b0;
			act_toggle: return !cur;
		endcase
	endfunction : act

	// later stages win, so compare0 has the last word on a clash
	function automatic logic drive(input logic cur, input logic [7:0] c);
		logic v;
		v = act(cur, over_underflow_event, c[`OC_OUF_LSB+:2]);
		v = act(v, compare1_event, c[`OC_CM1_LSB+:2]);
		return act(v, compare0_event, c[`OC_CM0_LSB+:2]);
	endfunction : drive

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_a_control_reg_q <= `RST_BYTE;
			output_b_control_reg_q <= `RST_BYTE;
			wave_a_q               <= 1'b0;
			wave_b_q               <= 1'b0;
		end else if (clk_en) begin
			wave_a_q <= drive(wave_a_q, output_a_control_reg_q);
			wave_b_q <= drive(wave_b_q, output_b_control_reg_q);
			if (wr && hit(paddr, `OFS_OUT_A_CTRL)) begin
				output_a_control_reg_q <= pwdata[7:0];
				wave_a_q               <= pwdata[`OC_PRESET];
			end
			if (wr && hit(paddr, `OFS_OUT_B_CTRL)) begin
				output_b_control_reg_q <= pwdata[7:0];
				wave_b_q               <= pwdata[`OC_PRESET];
			end
		end
	end

	assign wave_output_a = wave_a_q;
	assign wave_output_b = wave_b_q;
	assign chip_event = clk_en &&
		((over_underflow_event && output_a_control_reg_q[`OC_CHIP_EV]) ||
		(compare0_event && output_b_control_reg_q[`OC_CHIP_EV]));

	// ---------------------------------------------------------------
	// dma channels
	// ---------------------------------------------------------------
	dma_state_t state_q;
	logic       chan_cap_q, cap_req_q, cmp_req_q, word_done, eob_cap, eob_cmp;
	logic       cap_dma_on, cmp_dma_on;
	assign cap_dma_on = irq_dma_mask_reg_q[`MSK_CP0_DMA];
	assign cmp_dma_on = irq_dma_mask_reg_q[`MSK_CM0_DMA];
	assign word_done  = clk_en && state_q == dma_low && dma_byte_done;
	assign eob_cap    = word_done && dma_block_end && chan_cap_q;
	assign eob_cmp    = word_done && dma_block_end && !chan_cap_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= dma_idle;
			chan_cap_q <= 1'b0;
			cap_req_q  <= 1'b0;
			cmp_req_q  <= 1'b0;
		end else if (clk_en) begin
			if (capture0_event && cap_dma_on)
				cap_req_q <= 1'b1;
			else if (word_done && chan_cap_q)
				cap_req_q <= 1'b0;
			if (compare0_event && cmp_dma_on)
				cmp_req_q <= 1'b1;
			else if (word_done && !chan_cap_q)
				cmp_req_q <= 1'b0;
			unique case (state_q)
				dma_idle: begin
					if (cap_req_q && cap_dma_on) begin
						chan_cap_q <= 1'b1;
						state_q    <= dma_high;
					end else if (cmp_req_q && cmp_dma_on) begin
						chan_cap_q <= 1'b0;
						state_q    <= dma_high;
					end
				end
				dma_high: if (dma_byte_done) state_q <= dma_low;
				dma_low:  if (dma_byte_done) state_q <= dma_idle;
			endcase
		end
	end

	assign dma_request         = state_q != dma_idle;
	assign dma_capture_channel = chan_cap_q;
	assign dma_priority = (state_q == dma_low) ? `PRIO_TOP
		: (chan_cap_q ? `VEC_CAPTURE : `VEC_COMPARE);
	assign dma_address_used = !dma_counter_pointer_reg_q[`PTR_REG_TO_REG];
	assign dma_counter_ptr  = {dma_counter_pointer_reg_q[7:2],
		dma_address_used && !chan_cap_q, state_q == dma_low};
	assign dma_address_ptr  = {dma_address_pointer_reg_q[7:2],
		!chan_cap_q, state_q == dma_low};

	// ---------------------------------------------------------------
	// flags, masks, interrupt
	// ---------------------------------------------------------------
	logic [7:0] flag_set, flag_clr, mask_kill;
	logic [1:0] eob_clr;
	logic       wr_flag;
	assign wr_flag = wr && hit(paddr, `OFS_TIMER_FLAG);
	assign flag_clr = wr_flag ? pwdata[7:0] : 8'h00;
	assign eob_clr  = (wr && hit(paddr, `OFS_DMA_STATUS)) ? pwdata[1:0] : 2'h0;

	always_comb begin
		flag_set = 8'h00;
		flag_set[`FLG_CP0] = cap_dma_on ? eob_cap : capture0_event;
		flag_set[`FLG_CM0] = cmp_dma_on ? eob_cmp : compare0_event;
		flag_set[`FLG_CP1] = capture1_event;
		flag_set[`FLG_CM1] = compare1_event;
		flag_set[`FLG_OUF] = over_underflow_event;
		flag_set[`FLG_CP0_OVR] = capture0_event &&
			(cap_dma_on ? cap_req_q : timer_flag_reg_q[`FLG_CP0]);
		flag_set[`FLG_CM0_OVR] = compare0_event &&
			(cmp_dma_on ? cmp_req_q : timer_flag_reg_q[`FLG_CM0]);
		mask_kill = 8'h00;
		mask_kill[`MSK_CP0_DMA] = eob_cap && end_of_block_q[0];
		mask_kill[`MSK_CM0_DMA] = eob_cmp && end_of_block_q[1];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_flag_reg_q   <= `RST_BYTE;
			irq_dma_mask_reg_q <= `RST_BYTE;
			end_of_block_q     <= 2'h0;
		end else if (clk_en) begin
			timer_flag_reg_q <= (timer_flag_reg_q & ~flag_clr) | flag_set;
			end_of_block_q   <= (end_of_block_q & ~eob_clr) | {eob_cmp, eob_cap};
			if (wr && hit(paddr, `OFS_IRQ_DMA_MASK))
				irq_dma_mask_reg_q <= pwdata[7:0] & ~mask_kill;
			else
				irq_dma_mask_reg_q <= irq_dma_mask_reg_q & ~mask_kill;
		end
	end

	logic [7:0] live, flag_mask;
	logic       grp_ovf, grp_cap, grp_cmp;
	assign flag_mask = {3'h0, irq_dma_mask_reg_q[`MSK_OUF], irq_dma_mask_reg_q[`MSK_CM1:`MSK_CP0]};
	assign live    = timer_flag_reg_q & flag_mask;
	assign grp_ovf = live[`FLG_OUF];
	assign grp_cap = live[`FLG_CP0] || live[`FLG_CP1];
	assign grp_cmp = live[`FLG_CM0] || live[`FLG_CM1];
	assign irq_request = irq_dma_mask_reg_q[`MSK_GLOBAL] &&
		(grp_ovf || grp_cap || grp_cmp);
	assign irq_vector = {irq_vector_reg_q[7:3], grp_ovf ? `VEC_OVF
		: (grp_cap ? `VEC_CAPTURE : `VEC_COMPARE)};

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_last_byte;
		clk_en && state_q == dma_low && dma_byte_done && dma_block_end;
	endsequence

	a_trig_down_wins: assert property (mode == `MODE_TRIG_UD && a_edge && b_edge
		&& clk_en |=> !count_up || mode != `MODE_TRIG_UD) else $error("down trigger lost");
	a_level_dir: assert property (mode == `MODE_LEVEL_UD |-> count_up == event_input_a)
		else $error("level direction wrong");
	a_autodisc_hold: assert property (mode == `MODE_AUTODISC && event_input_a
		|-> !step_up && !step_down) else $error("step with a high");
	a_gate_low_runs: assert property (mode == `MODE_TRIG_GATE
		|-> count_gate == !event_input_b) else $error("gate sense wrong");
	a_preset_loads: assert property (wr && hit(paddr, `OFS_OUT_A_CTRL)
		|=> wave_output_a == $past(pwdata[`OC_PRESET])) else $error("preset lost");
	a_ovf_vector: assert property (irq_request && grp_ovf |-> irq_vector[2:0] == 3'h0)
		else $error("overflow vector wrong");
	a_global_mask: assert property (!irq_dma_mask_reg_q[`MSK_GLOBAL] |-> !irq_request)
		else $error("global mask ignored");
	a_cmp_overrun: assert property (compare0_event && timer_flag_reg_q[`FLG_CM0]
		&& clk_en && !cmp_dma_on |=> timer_flag_reg_q[`FLG_CM0_OVR]) else $error("overrun missed");
	a_second_prio: assert property (state_q == dma_low |-> dma_priority == 3'h0)
		else $error("second byte not top");
	a_eob_protect: assert property (s_last_byte ##0 chan_cap_q && end_of_block_q[0]
		|=> !irq_dma_mask_reg_q[`MSK_CP0_DMA]) else $error("dma not blocked");
	a_cap_first: assert property (clk_en && state_q == dma_idle && cap_req_q
		&& cap_dma_on |=> state_q == dma_high && chan_cap_q) else $error("capture not first");

endmodule : mft_io
`default_nettype wire

/* logic/mft_io_defs.svh */
// register offsets, field positions, reset values and codes of the timer i/o block
// assumes: included by bare name after the package
`ifndef MFT_IO_DEFS_SVH
`define MFT_IO_DEFS_SVH

// ---------------------------------------------------------------
// apb byte offsets
// ---------------------------------------------------------------
`define OFS_INPUT_MODE   8'h00
`define OFS_OUT_A_CTRL   8'h04
`define OFS_OUT_B_CTRL   8'h08
`define OFS_IRQ_VECTOR   8'h0C
`define OFS_IRQ_DMA_MASK 8'h10
`define OFS_TIMER_FLAG   8'h14
`define OFS_DMA_CNT_PTR  8'h18
`define OFS_DMA_ADR_PTR  8'h1C
`define OFS_DMA_STATUS   8'h20

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define INM_SOFT_DIR     4
`define OC_PRESET        0
`define OC_CM0_LSB       1
`define OC_CM1_LSB       3
`define OC_OUF_LSB       5
`define OC_CHIP_EV       7
`define MSK_OUF          0
`define MSK_CP0          1
`define MSK_CP1          2
`define MSK_CM0          3
`define MSK_CM1          4
`define MSK_CP0_DMA      5
`define MSK_CM0_DMA      6
`define MSK_GLOBAL       7
`define FLG_CP0          0
`define FLG_CP1          1
`define FLG_CM0          2
`define FLG_CM1          3
`define FLG_OUF          4
`define FLG_CP0_OVR      5
`define FLG_CM0_OVR      6
`define PTR_REG_TO_REG   0

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define RST_BYTE         8'h00
`define MODE_TRIG_UD     4'hA
`define MODE_LEVEL_UD    4'hB
`define MODE_AUTODISC    4'hC
`define MODE_TRIG_EXTB   4'hD
`define MODE_EXTA_TRIG   4'hE
`define MODE_TRIG_GATE   4'hF
`define VEC_COMPARE      3'h6
`define VEC_CAPTURE      3'h4
`define VEC_OVF          3'h0
`define PRIO_TOP         3'h0

`endif

/* logic/mft_io_pkg.sv */
// types shared by the timer i/o block
// assumes: nothing beyond a systemverilog compiler
`default_nettype none
package mft_io_pkg;
	typedef enum logic [1:0] {act_nop, act_set, act_reset, act_toggle} action_t;
	typedef enum logic [1:0] {dma_idle, dma_high, dma_low} dma_state_t;
endpackage : mft_io_pkg
`default_nettype wire

/* dv/mft_far_model.sv */
// far side of the timer i/o block: pulse source on the two pins and a dma byte mover
// assumes: shares pclk with the block; the bench calls drive() for pin activity
`timescale 1ns/1ps
`default_nettype none

module mft_far_model (
	// clock
	input  wire logic       pclk,
	// dma controller side
	input  wire logic       dma_request,
	input  wire logic [3:0] lag,
	input  wire logic       end_of_block,
	output logic            dma_byte_done,
	output logic            dma_block_end,
	// pulse sources
	output logic            pin_a,
	output logic            pin_b
);
	// ---------------------------------------------------------------
	// byte mover
	// ---------------------------------------------------------------
	logic [3:0] cnt_q;

	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
		dma_byte_done = 1'b0;
		cnt_q = 4'h0;
	end

	// one byte per request after lag idle cycles; done never stays up two cycles
	always @(posedge pclk) begin
		dma_byte_done <= dma_request === 1'b1 && !dma_byte_done && cnt_q == lag;
		if (dma_request === 1'b1 && !dma_byte_done)
			cnt_q <= (cnt_q == lag) ? 4'h0 : cnt_q + 4'h1;
	end

	// block end is only meaningful beside done; otherwise show the wrong level
	assign dma_block_end = dma_byte_done ? end_of_block : ~end_of_block;

	// ---------------------------------------------------------------
	// pins
	// ---------------------------------------------------------------
	task automatic drive(input logic a, input logic b);
		@(posedge pclk);
		pin_a <= a;
		pin_b <= b;
		@(negedge pclk);
	endtask : drive
endmodule : mft_far_model

`default_nettype wire

/* dv/multifunction_timer_io_irq_dma_test.sv */
// self-checking bench of the timer i/o block: pin modes, outputs, vectors, dma
// assumes: design and far model compiled first; one 10 MHz clock, apb master here
`timescale 1ns/1ps
`default_nettype none
`include "mft_io_defs.svh"

module multifunction_timer_io_irq_dma_test
	import mft_io_pkg::*;
;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, irq_vector, dma_counter_ptr, dma_address_ptr, ca, cb;
	logic [31:0] pwdata, prdata, rnd, rd;
	logic        event_input_a, event_input_b, wave_output_a, wave_output_b;
	logic        compare0_event, compare1_event, over_underflow_event;
	logic        capture0_event, capture1_event, count_up, step_up, step_down;
	logic        ext_clock_pulse, count_gate, reg0_trigger, reg1_capture, chip_event;
	logic        irq_request, dma_request, dma_capture_channel, dma_address_used;
	logic        dma_byte_done, dma_block_end, end_of_block, err, ovf_chip_event_enable;
	logic [2:0]  dma_priority;
	logic [3:0]  lag;
	logic [4:0]  evs;
	logic [20:0] seen[$];
	logic [4:0]  gev[4] = '{5'h02, 5'h10, 5'h04, 5'h05};
	logic [2:0]  gvec[4] = '{3'h6, 3'h4, 3'h0, 3'h0};
	int          fail_count, tests_run, cyc;

	assign {capture1_event, capture0_event, over_underflow_event} = evs[4:2];
	assign {compare1_event, compare0_event} = evs[1:0];

	mft_io mft_io_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .event_input_a, .event_input_b,
		.wave_output_a, .wave_output_b, .compare0_event, .compare1_event,
		.over_underflow_event, .capture0_event, .capture1_event, .count_up, .step_up,
		.step_down, .ext_clock_pulse, .count_gate, .reg0_trigger, .reg1_capture,
		.chip_event, .irq_request, .irq_vector, .dma_request, .dma_capture_channel,
		.dma_priority, .dma_counter_ptr, .dma_address_ptr, .dma_address_used,
		.dma_byte_done, .dma_block_end);

	mft_far_model mft_far_model_inst (.pclk, .dma_request, .lag, .end_of_block, .dma_byte_done,
		.dma_block_end, .pin_a(event_input_a), .pin_b(event_input_b));

	// ---------------------------------------------------------------
	// helpers and model
	// ---------------------------------------------------------------
	always #50 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	always @(negedge pclk) begin
		if (dma_request === 1'b1 && dma_byte_done === 1'b1)
			seen.push_back({dma_capture_channel, dma_priority, dma_counter_ptr,
				dma_address_used, dma_address_ptr});
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// rd and err are taken at the edge that ends the access, and the request drops there
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask : apb

	task automatic ev(input logic [4:0] b);
		@(posedge pclk);
		evs <= b;
		@(negedge pclk);
		ovf_chip_event_enable = chip_event;
		@(posedge pclk);
		evs <= 5'h00;
		@(negedge pclk);
	endtask : ev

	task automatic ps(input logic a, input logic b, input int n);
		repeat (n) mft_far_model_inst.drive(a, b);
	endtask : ps

	task automatic dma_run(input logic [4:0] b, input int n);
		seen.delete();
		ev(b);
		for (int k = 0; k < 80 && seen.size() < n; k++)
			@(negedge pclk);
	endtask : dma_run

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic act(input logic w, input logic [1:0] c);
		case (c)
			2'h1: act = 1'b1;
			2'h2: act = 1'b0;
			2'h3: act = ~w;
			default: act = w;
		endcase
	endfunction : act

	// overflow first, compare0 last: the last action wins
	function automatic logic wave(input logic [7:0] c, input logic [2:0] e);
		logic w;
		w = c[0];
		if (e[2]) w = act(w, c[6:5]);
		if (e[1]) w = act(w, c[4:3]);
		if (e[0]) w = act(w, c[2:1]);
		return w;
	endfunction : wave

	// capture channel first, high byte then low byte at top priority
	function automatic logic [20:0] dexp(input int k, input logic [7:0] p, input logic [7:0] q);
		logic ch;
		ch = (k < 2);
		return {ch, (k % 2 == 1) ? 3'h0 : (ch ? 3'h4 : 3'h6), p[7:2], ~ch, k[0], 1'b1,
			q[7:2], ~ch, k[0]};
	endfunction : dexp

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{pclk, presetn, psel, penable, pwrite, end_of_block, cyc} = '0;
		{paddr, pwdata, evs, fail_count, tests_run} = '0;
		clk_en = 1'b1;
		lag = 4'h3;
		rnd = 32'h45263405;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 32; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, 8'h24, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, `OFS_INPUT_MODE, {27'h0, 1'b1, `MODE_TRIG_UD});
		ps(1, 0, 2);
		chk(count_up, 1'b1);
		ps(0, 1, 2);
		chk(count_up, 1'b0);
		ps(1, 0, 1);
		ps(0, 0, 1);
		ps(1, 1, 2);
		chk(count_up, 1'b0);
		apb(1'b1, `OFS_INPUT_MODE, {27'h0, 1'b1, `MODE_LEVEL_UD});
		ps(0, 0, 1);
		chk(count_up, 1'b0);
		ps(1, 0, 1);
		chk(count_up, 1'b1);
		apb(1'b1, `OFS_INPUT_MODE, {27'h0, 1'b1, `MODE_AUTODISC});
		ps(0, 0, 1);
		ps(0, 1, 1);
		chk({step_up, step_down}, 2'b10);
		ps(0, 0, 1);
		chk({step_up, step_down}, 2'b01);
		ps(1, 1, 1);
		chk({step_up, step_down}, 2'b00);
		apb(1'b1, `OFS_INPUT_MODE, {28'h0, `MODE_TRIG_EXTB});
		ps(0, 0, 1);
		ps(1, 0, 1);
		chk({reg0_trigger, ext_clock_pulse}, 2'b10);
		ps(0, 1, 1);
		chk({reg0_trigger, ext_clock_pulse}, 2'b01);
		apb(1'b1, `OFS_INPUT_MODE, {28'h0, `MODE_EXTA_TRIG});
		ps(0, 0, 1);
		ps(0, 1, 1);
		chk({reg1_capture, ext_clock_pulse}, 2'b10);
		ps(1, 0, 1);
		chk({reg1_capture, ext_clock_pulse}, 2'b01);
		apb(1'b1, `OFS_INPUT_MODE, {28'h0, `MODE_TRIG_GATE});
		ps(0, 1, 1);
		chk({count_gate, reg0_trigger}, 2'b00);
		ps(1, 0, 1);
		chk({count_gate, reg0_trigger}, 2'b11);
		$display("test input modes done");
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			ca = rnd[7:0];
			cb = rnd[15:8];
			apb(1'b1, `OFS_OUT_A_CTRL, {24'h0, ca});
			apb(1'b1, `OFS_OUT_B_CTRL, {24'h0, cb});
			chk({wave_output_a, wave_output_b}, {ca[0], cb[0]});
			ev({2'b00, rnd[18:16]});
			chk({wave_output_a, wave_output_b}, {wave(ca, rnd[18:16]), wave(cb, rnd[18:16])});
			chk(ovf_chip_event_enable, (ca[7] & rnd[18]) | (cb[7] & rnd[16]));
		end
		@(posedge pclk) clk_en <= 1'b0;
		ev(5'h07);
		chk({pready, ovf_chip_event_enable, wave_output_a, wave_output_b},
			{2'b00, wave(ca, rnd[18:16]), wave(cb, rnd[18:16])});
		@(posedge pclk) clk_en <= 1'b1;
		$display("test outputs done");
		apb(1'b1, `OFS_IRQ_VECTOR, 32'hAD);
		apb(1'b0, `OFS_IRQ_VECTOR, 32'h0);
		chk(rd, 32'hA8);
		apb(1'b1, `OFS_IRQ_DMA_MASK, 32'h9F);
		for (int g = 0; g < 4; g++) begin
			apb(1'b1, `OFS_TIMER_FLAG, 32'hFF);
			ev(gev[g]);
			chk({irq_request, irq_vector}, {1'b1, 5'h15, gvec[g]});
		end
		apb(1'b1, `OFS_IRQ_DMA_MASK, 32'h1F);
		chk(irq_request, 1'b0);
		apb(1'b1, `OFS_IRQ_DMA_MASK, 32'h97);
		apb(1'b1, `OFS_TIMER_FLAG, 32'hFF);
		ev(5'h01);
		chk(irq_request, 1'b0);
		ev(5'h09);
		ev(5'h09);
		apb(1'b0, `OFS_TIMER_FLAG, 32'h0);
		chk(rd, 32'h65);
		$display("test interrupts done");
		apb(1'b1, `OFS_TIMER_FLAG, 32'hFF);
		apb(1'b1, `OFS_DMA_CNT_PTR, 32'hA8);
		apb(1'b1, `OFS_DMA_ADR_PTR, 32'h54);
		apb(1'b1, `OFS_IRQ_DMA_MASK, 32'hCA);
		dma_run(5'h08, 1);
		chk(seen.size(), 32'h0);
		apb(1'b1, `OFS_TIMER_FLAG, 32'hFF);
		apb(1'b1, `OFS_IRQ_DMA_MASK, 32'hEA);
		dma_run(5'h09, 4);
		chk(seen.size(), 32'h4);
		foreach (seen[k]) chk(seen[k], dexp(k, 8'hA8, 8'h54));
		apb(1'b0, `OFS_TIMER_FLAG, 32'h0);
		chk({irq_request, rd}, {1'b0, 32'h0});
		end_of_block = 1'b1;
		lag = 4'h0;
		dma_run(5'h09, 4);
		apb(1'b0, `OFS_TIMER_FLAG, 32'h0);
		chk({irq_request, rd}, {1'b1, 32'h05});
		apb(1'b0, `OFS_DMA_STATUS, 32'h0);
		chk(rd[1:0], 2'b11);
		dma_run(5'h09, 4);
		apb(1'b0, `OFS_IRQ_DMA_MASK, 32'h0);
		chk(rd, 32'h8A);
		apb(1'b1, `OFS_DMA_CNT_PTR, 32'hA9);
		chk(dma_address_used, 1'b0);
		$display("test dma done");
		report_and_stop();
	end
endmodule : multifunction_timer_io_irq_dma_test

`default_nettype wire
